// ===== src/fqm_pkg.sv
// Constants, types and GF(256) helpers for the FEC, interleave and QAM mapping datapath
package fqm_pkg;
   localparam int BYTE_W = 8;
   localparam int IQ_W = 4;
   localparam int BUF_W = 16;
   localparam int RS_CHECK = 16;
   localparam int RS_CODE = 204;
   localparam int RS_MSG = RS_CODE - RS_CHECK;
   localparam logic [7:0] GF_POLY = 8'h1D;
   localparam int IL_N = 204;
   localparam int IL_B = 12;
   localparam int IL_M = 17;
   localparam int IL_MEM = IL_M * IL_B * (IL_B - 1) / 2;
   localparam int IL_AW = 11;
   localparam int RS_LAT = 2;
   localparam int IL_LAT = 3;
   localparam logic [4:0] SLOT_BITS = 5'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam int CTRL_RS_EN = 0;
   localparam int CTRL_IL_EN = 1;
   localparam int CTRL_ZFILL = 2;
   localparam int CTRL_DIFF_OFF = 3;
   localparam int CTRL_SYMBOL_WIDTH_MINUS_ONE = 8;
   localparam logic [31:0] CTRL_MASK = 32'h0000_070F;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0703;
   localparam int STAT_PARITY = 0;
   localparam int STAT_SEEN = 1;
   localparam int STAT_BRANCH = 4;

   typedef enum logic {FQM_MSG, FQM_PAR} fqm_rs_state_e;

   // Multiply two field elements, reducing by the primitive polynomial
   function automatic logic [7:0] fqm_gf_mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      logic [7:0] x;
      r = 8'h00;
      x = a;
      for (int k = 0; k < BYTE_W; k++)
      begin
         if (b[k])
            r = r ^ x;
         x = x[7] ? ((x << 1) ^ GF_POLY) : (x << 1);
      end
      return r;
   endfunction

   // Coefficients g0..g15 of the product of (x + alpha^i), i = 0..15
   function automatic logic [8*RS_CHECK-1:0] fqm_gen_poly();
      logic [7:0] g [RS_CHECK+1];
      logic [7:0] root;
      logic [8*RS_CHECK-1:0] r;
      for (int k = 0; k <= RS_CHECK; k++)
         g[k] = 8'h00;
      g[0] = 8'h01;
      root = 8'h01;
      for (int i = 0; i < RS_CHECK; i++)
      begin
         for (int k = RS_CHECK; k > 0; k--)
            g[k] = g[k-1] ^ fqm_gf_mul(g[k], root);
         g[0] = fqm_gf_mul(g[0], root);
         root = fqm_gf_mul(root, 8'h02);
      end
      for (int k = 0; k < RS_CHECK; k++)
         r[8*k +: 8] = g[k];
      return r;
   endfunction
endpackage

// ===== src/fqm_top.sv
// RS encoder, convolutional interleaver, symbol cutter, differential encoder and QAM mapper
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module fqm_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [fqm_pkg::BYTE_W-1:0] in_data,
   input wire logic in_valid,
   input wire logic block_start_in,
   output logic in_ready,
   output logic out_valid,
   output logic [fqm_pkg::IQ_W-1:0] i_out,
   output logic [fqm_pkg::IQ_W-1:0] q_out
);
   import fqm_pkg::*;

   localparam logic [8*RS_CHECK-1:0] GEN = fqm_gen_poly();

   // Start offset of each branch inside the shared delay memory
   function automatic logic [IL_AW-1:0] branch_base(input logic [3:0] b);
      int v;
      v = IL_M * int'(b) * (int'(b) - 1) / 2;
      return v[IL_AW-1:0];
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      if (a == ADDR_CTRL)
         return 1'b1;
      else if (a == ADDR_STAT)
         return 1'b1;
      else
         return 1'b0;
   endfunction

   // Left-align n bits (hi first, then src from its MSB) and pad with ones
   function automatic logic [IQ_W-1:0] align_iq(input logic hi, input logic [5:0] src,
                                                input logic [3:0] n);
      logic [IQ_W-1:0] r;
      r = '1;
      if (n != 4'h0)
         r[IQ_W-1] = hi;
      for (int k = 1; k < IQ_W; k++)
         if (k < int'(n))
            r[IQ_W-1-k] = src[6-k];
      return r;
   endfunction

   logic [31:0] ctrl;
   logic rs_en;
   logic il_en;
   logic zfill;
   logic diff_off;
   logic [3:0] m_bits;
   logic acc_phase;

   // Register bus
   assign rs_en = ctrl[CTRL_RS_EN];
   assign il_en = ctrl[CTRL_IL_EN];
   assign zfill = ctrl[CTRL_ZFILL];
   assign diff_off = ctrl[CTRL_DIFF_OFF];
   assign m_bits = {1'b0, ctrl[CTRL_SYMBOL_WIDTH_MINUS_ONE +: 3]} + 4'h1;
   assign acc_phase = psel & penable & pready;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= CTRL_RESET;
      else if (acc_phase && pwrite && paddr == ADDR_CTRL)
         ctrl <= pwdata & CTRL_MASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= psel & ~penable;
   end

   fqm_rs_state_e rs_state;
   logic seen_fall;
   logic [3:0] branch;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= ~addr_mapped(paddr);
         if (paddr == ADDR_CTRL)
            prdata <= ctrl;
         else if (paddr == ADDR_STAT)
         begin
            prdata <= 32'h0000_0000;
            prdata[STAT_PARITY] <= (rs_state == FQM_PAR);
            prdata[STAT_SEEN] <= seen_fall;
            prdata[STAT_BRANCH +: 4] <= branch;
         end
         else
            prdata <= 32'h0000_0000;
      end
   end

   // Byte slot pacing: one slot per eight bits of symbol bandwidth
   logic [4:0] acc;
   logic slot;
   logic [4:0] next_acc;
   logic next_slot;

   assign next_acc = acc + {1'b0, m_bits} - (slot ? SLOT_BITS : 5'h00);
   assign next_slot = (next_acc >= SLOT_BITS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc <= 5'h00;
         slot <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         slot <= next_slot;
      end
   end

   // Reed-Solomon encoder
   logic [7:0] msg_cnt;
   logic [3:0] par_cnt;
   logic [8*RS_CHECK-1:0] lfsr;
   logic accept;
   logic par_slot;
   logic [7:0] cur_cnt;
   fqm_rs_state_e next_rs_state;

   assign accept = in_ready & in_valid;
   assign par_slot = slot & (rs_state == FQM_PAR);
   assign cur_cnt = block_start_in ? 8'h00 : msg_cnt;

   always_comb
   begin
      next_rs_state = rs_state;
      case (rs_state)
         FQM_MSG:
            if (accept && rs_en && cur_cnt == 8'(RS_MSG - 1))
               next_rs_state = FQM_PAR;
         FQM_PAR:
            if (par_slot && par_cnt == 4'(RS_CHECK - 1))
               next_rs_state = FQM_MSG;
         default:
            next_rs_state = FQM_MSG;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rs_state <= FQM_MSG;
         in_ready <= 1'b0;
         msg_cnt <= 8'h00;
         par_cnt <= 4'h0;
      end
      else
      begin
         rs_state <= next_rs_state;
         in_ready <= next_slot & (next_rs_state == FQM_MSG);
         if (accept)
            msg_cnt <= (cur_cnt == 8'(RS_MSG - 1)) ? 8'h00 : cur_cnt + 8'h01;
         if (par_slot)
            par_cnt <= par_cnt + 4'h1;
      end
   end

   // Parity register, systematic division by the generator
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lfsr <= '0;
      else if (accept && rs_en)
      begin
         logic [8*RS_CHECK-1:0] base;
         logic [7:0] fb;
         base = block_start_in ? '0 : lfsr;
         fb = in_data ^ base[8*RS_CHECK-1 -: 8];
         for (int k = RS_CHECK - 1; k > 0; k--)
            lfsr[8*k +: 8] <= base[8*(k-1) +: 8] ^ fqm_gf_mul(fb, GEN[8*k +: 8]);
         lfsr[7:0] <= fqm_gf_mul(fb, GEN[7:0]);
      end
      else if (par_slot)
         lfsr <= {lfsr[8*RS_CHECK-9:0], 8'h00};
   end

   logic ra_v;
   logic ra_s;
   logic [7:0] ra_d;
   logic rb_v;
   logic rb_s;
   logic [7:0] rb_d;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ra_v <= 1'b0;
         ra_s <= 1'b0;
         ra_d <= 8'h00;
         rb_v <= 1'b0;
         rb_s <= 1'b0;
         rb_d <= 8'h00;
      end
      else
      begin
         ra_v <= accept | par_slot;
         ra_s <= accept & block_start_in;
         ra_d <= par_slot ? lfsr[8*RS_CHECK-1 -: 8] : in_data;
         rb_v <= ra_v;
         rb_s <= ra_s;
         rb_d <= ra_d;
      end
   end

   // Convolutional interleaver
   logic [3:0] cur_b;
   logic [7:0] ptr [IL_B];
   logic bs_prev;

   assign cur_b = (rb_s || !il_en) ? 4'h0 : branch;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         branch <= 4'h0;
         bs_prev <= 1'b0;
         seen_fall <= 1'b0;
      end
      else
      begin
         bs_prev <= block_start_in;
         if (bs_prev && !block_start_in)
            seen_fall <= 1'b1;
         if (rb_v)
            branch <= (cur_b == 4'(IL_B - 1)) ? 4'h0 : cur_b + 4'h1;
      end
   end

   assign ptr[0] = 8'h00;
   for (genvar g = 1; g < IL_B; g++)
   begin : g_ptr
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            ptr[g] <= 8'h00;
         else if (rb_v && cur_b == 4'(g))
            ptr[g] <= (ptr[g] == 8'(IL_M * g - 1)) ? 8'h00 : ptr[g] + 8'h01;
      end
   end

   logic i1_v;
   logic i1_s;
   logic i1_b0;
   logic i1_z;
   logic [7:0] i1_d;
   logic [IL_AW-1:0] i1_addr;
   logic i2_v;
   logic i2_s;
   logic i2_b0;
   logic [7:0] i2_dir;
   logic [7:0] i2_old;
   logic i3_v;
   logic i3_s;
   logic [7:0] i3_d;
   logic [7:0] mem [IL_MEM];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         i1_v <= 1'b0;
         i1_s <= 1'b0;
         i1_b0 <= 1'b1;
         i1_z <= 1'b0;
         i1_d <= 8'h00;
         i1_addr <= '0;
         i2_v <= 1'b0;
         i2_s <= 1'b0;
         i2_b0 <= 1'b1;
         i2_dir <= 8'h00;
         i3_v <= 1'b0;
         i3_s <= 1'b0;
         i3_d <= 8'h00;
      end
      else
      begin
         i1_v <= rb_v;
         i1_s <= rb_s;
         i1_b0 <= (cur_b == 4'h0);
         i1_z <= zfill & ~seen_fall;
         i1_d <= rb_d;
         i1_addr <= branch_base(cur_b) + IL_AW'(ptr[cur_b]);
         i2_v <= i1_v;
         i2_s <= i1_s;
         i2_b0 <= i1_b0;
         i2_dir <= i1_d;
         i3_v <= i2_v;
         i3_s <= i2_s;
         i3_d <= i2_b0 ? i2_dir : i2_old;
      end
   end

   // Delay memory: read the oldest byte of the branch, then overwrite it
   always_ff @(posedge pclk)
   begin
      if (i1_v && !i1_b0)
      begin
         i2_old <= mem[i1_addr];
         mem[i1_addr] <= i1_z ? 8'h00 : i1_d;
      end
   end

   // Bytes to m-tuples
   logic [BUF_W-1:0] bitbuf;
   logic [4:0] bitcnt;
   logic emit;
   logic [BUF_W-1:0] next_buf;
   logic [4:0] next_cnt;
   logic sym_v;
   logic sym_s;
   logic [7:0] sym;

   assign emit = (bitcnt >= {1'b0, m_bits});

   always_comb
   begin
      next_buf = emit ? (bitbuf << m_bits) : bitbuf;
      next_cnt = emit ? bitcnt - {1'b0, m_bits} : bitcnt;
      if (i3_v)
      begin
         next_buf = next_buf | ({i3_d, 8'h00} >> next_cnt);
         next_cnt = next_cnt + SLOT_BITS;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bitbuf <= '0;
         bitcnt <= 5'h00;
         sym_v <= 1'b0;
         sym_s <= 1'b0;
         sym <= 8'h00;
      end
      else
      begin
         bitbuf <= next_buf;
         bitcnt <= next_cnt;
         sym_v <= emit;
         sym_s <= i3_v & i3_s;
         sym <= bitbuf[BUF_W-1 -: 8];
      end
   end

   // Differential encoder and mapper; sym holds the symbol left-aligned
   logic a_bit;
   logic b_bit;
   logic [5:0] low;
   logic i_prev;
   logic q_prev;
   logic ik;
   logic qk;
   logic [3:0] w_i;
   logic [3:0] w_q;

   assign a_bit = sym[7];
   assign b_bit = sym[6];
   assign low = sym[5:0] & (6'h3F << (4'h8 - m_bits));
   assign w_i = (m_bits + 4'h1) >> 1;
   assign w_q = m_bits >> 1;

   always_comb
   begin
      if (diff_off)
      begin
         ik = a_bit;
         qk = b_bit;
      end
      else if (a_bit ^ b_bit)
      begin
         ik = a_bit ^ q_prev;
         qk = b_bit ^ i_prev;
      end
      else
      begin
         ik = a_bit ^ i_prev;
         qk = b_bit ^ q_prev;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         i_prev <= 1'b0;
         q_prev <= 1'b0;
         out_valid <= 1'b0;
         i_out <= '1;
         q_out <= '1;
      end
      else
      begin
         if (sym_s)
         begin
            i_prev <= 1'b0;
            q_prev <= 1'b0;
         end
         else if (sym_v)
         begin
            i_prev <= ik;
            q_prev <= qk;
         end
         out_valid <= sym_v;
         if (sym_v)
         begin
            i_out <= align_iq(ik, low, w_i);
            q_out <= align_iq(qk, low << (w_i - 4'h1), w_q);
         end
      end
   end

endmodule // fqm_top

// ===== bench/fqm_top_assertions.sv
// Port checker for the coded QAM datapath
`timescale 1ns/100ps
module fqm_checker
   import fqm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [fqm_pkg::BYTE_W-1:0] in_data,
   input wire logic in_valid,
   input wire logic block_start_in,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic [fqm_pkg::IQ_W-1:0] i_out,
   input wire logic [fqm_pkg::IQ_W-1:0] q_out
);
   logic [31:0] ctrl;
   logic [7:0] acc_cnt;
   logic [3:0] fill;
   logic acc;
   logic m8;
   logic byp;
   assign acc = in_valid && in_ready;
   assign m8 = ctrl[CTRL_SYMBOL_WIDTH_MINUS_ONE +: 3] == 3'h7;
   assign byp = m8 && !ctrl[CTRL_RS_EN];
   // Shadow of the control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= CTRL_RESET;
      else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
         ctrl <= pwdata & CTRL_MASK;
   end
   // Bytes taken since block start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_cnt <= 8'h00;
      else if (acc)
         acc_cnt <= block_start_in ? 8'h01 : acc_cnt + 8'h01;
   end
   always_comb
   begin
      case (ctrl[CTRL_SYMBOL_WIDTH_MINUS_ONE +: 3])
         3'h0, 3'h1: fill = 4'h7;
         3'h2, 3'h3: fill = 4'h3;
         3'h4, 3'h5: fill = 4'h1;
         default: fill = 4'h0;
      endcase
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rs_gap_a: assert property (ctrl[CTRL_RS_EN] && m8 && acc && acc_cnt == 8'hBB |=>
      !in_ready [*8] ##1 !in_ready [*8] ##1 in_ready) else $error("parity gap wrong");
   no_gap_a: assert property (byp && $past(byp) && $past(in_ready) |-> in_ready)
      else $error("gap without parity");
   bypass_lat_a: assert property (byp && !ctrl[CTRL_IL_EN] && acc |-> ##8 out_valid)
      else $error("bypass latency wrong");
   branch0_lat_a: assert property (byp && ctrl[CTRL_IL_EN] && acc && block_start_in
      |-> ##8 out_valid) else $error("branch zero latency wrong");
   first_sym_a: assert property (byp && acc && block_start_in |-> ##8
      (i_out[3] == $past(in_data[7], 8) && q_out[3] == $past(in_data[6], 8)))
      else $error("first symbol wrong");
   plain_map_a: assert property (byp && !ctrl[CTRL_IL_EN] && ctrl[CTRL_DIFF_OFF] && acc
      |-> ##8 ({i_out, q_out} == {$past(in_data[7], 8), $past(in_data[5:3], 8),
      $past(in_data[6], 8), $past(in_data[2:0], 8)})) else $error("mapping wrong");
   fill_ones_a: assert property (out_valid |-> (i_out & fill) == fill
      && (q_out & fill) == fill) else $error("low bits not ones");
   pacing_gap_a: assert property (not ((in_ready && !m8) [*8]))
      else $error("no idle slot in group");
   cover property (acc && block_start_in);
   cover property (ctrl[CTRL_RS_EN] && acc && acc_cnt == 8'hBB);
   cover property (out_valid && ctrl[CTRL_SYMBOL_WIDTH_MINUS_ONE +: 3] == 3'h5);
endmodule // fqm_checker

bind fqm_top fqm_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .in_data(in_data), .in_valid(in_valid), .block_start_in(block_start_in),
   .in_ready(in_ready), .out_valid(out_valid), .i_out(i_out), .q_out(q_out));

// ===== bench/fqm_src.sv
// Upstream byte source model
`timescale 1ns/100ps
module fqm_src
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_ready,
   output logic [7:0] in_data,
   output logic in_valid,
   output logic block_start_in
);
   logic [8:0] q[$];
   // Byte and strobe held until taken; released data is inverted
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_valid <= 1'b0;
         in_data <= 8'h00;
         block_start_in <= 1'b0;
      end
      else if (!in_valid || in_ready)
      begin
         if (q.size() > 0)
         begin
            {block_start_in, in_data} <= q.pop_front();
            in_valid <= 1'b1;
         end
         else
         begin
            in_valid <= 1'b0;
            block_start_in <= 1'b0;
            in_data <= ~in_data;
         end
      end
   end
endmodule // fqm_src

// ===== bench/fqm_top_tb.sv
// Self-checking bench for the coded QAM datapath
`timescale 1ns/100ps
module fqm_top_tb;
   import fqm_pkg::*;
   logic pclk = 1'b0;
   logic presetn;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] in_data;
   logic in_valid;
   logic block_start_in;
   logic in_ready;
   logic out_valid;
   logic [3:0] i_out;
   logic [3:0] q_out;
   logic [7:0] got[$];
   logic [31:0] rd;
   logic er;
   int cyc = 0;
   int t_acc = 0;
   int t_out = 0;
   int n_mismatch = 0;
   int checks = 0;

   fqm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_data(in_data), .in_valid(in_valid),
      .block_start_in(block_start_in), .in_ready(in_ready), .out_valid(out_valid),
      .i_out(i_out), .q_out(q_out));
   fqm_src u_src (.pclk(pclk), .presetn(presetn), .in_ready(in_ready),
      .in_data(in_data), .in_valid(in_valid), .block_start_in(block_start_in));

   always #2.5 pclk = ~pclk;

   // Collects symbols and acceptance times
   always @(posedge pclk)
   begin
      cyc++;
      if (in_valid === 1'b1 && in_ready === 1'b1 && block_start_in === 1'b1)
         t_acc = cyc;
      if (out_valid === 1'b1)
      begin
         if (got.size() == 0)
            t_out = cyc;
         got.push_back({i_out, q_out});
      end
   end

   task automatic print_verdict();
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic reg_case();
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("status reset", 32'h0, rd);
      apb(1'b1, 8'h08, 32'hFFFF_FFFF);
      chk("unmapped error", 32'h1, {31'h0, er});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", CTRL_RESET, rd);
      chk("mapped error", 32'h0, {31'h0, er});
      apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl mask", CTRL_MASK, rd);
   endtask

   task automatic run_case(input logic [31:0] c, input logic [23:0] b, input int nb,
                           input logic [31:0] x, input int ns, input logic lat);
      int k;
      apb(1'b1, ADDR_CTRL, c);
      repeat (4) @(posedge pclk);
      got.delete();
      for (k = 0; k < nb; k++)
         u_src.q.push_back({k == 0, b[8*(nb-1-k) +: 8]});
      k = 0;
      while (got.size() < ns && k < 1000)
      begin
         @(posedge pclk);
         k++;
      end
      repeat (20) @(posedge pclk);
      chk("symbol count", ns, got.size());
      for (k = 0; k < ns && k < got.size(); k++)
         chk("symbol iq", x[8*(ns-1-k) +: 8], got[k]);
      if (lat)
         chk("latency", 8, t_out - t_acc);
   endtask

   task automatic rs_case();
      int k;
      logic [7:0] b;
      logic [31:0] x;
      x = 32'h0;
      run_case(32'h0000_0709, 24'h0, 0, x, 0, 1'b0);
      got.delete();
      for (k = 0; k < 188; k++)
         u_src.q.push_back({k == 0, 8'(k * 7)});
      k = 0;
      while (got.size() < 204 && k < 1000)
      begin
         @(posedge pclk);
         k++;
      end
      repeat (20) @(posedge pclk);
      chk("coded block size", 204, got.size());
      for (k = 0; k < 188 && k < got.size(); k++)
      begin
         b = 8'(k * 7);
         chk("message byte", {b[7], b[5:3], b[6], b[2:0]}, got[k]);
      end
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("fall seen", 32'h1, {31'h0, rd[STAT_SEEN]});
   endtask

   // A fresh reset is the only way to clear the seen falling edge
   task automatic reset_case();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("status after reset", 32'h0, rd);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl after reset", CTRL_RESET, rd);
   endtask

   initial
   begin
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      reg_case();
      run_case(32'h0000_0108, 24'h0000B4, 1, 32'hF7FF_7F77, 4, 1'b0);
      run_case(32'h0000_0308, 24'h0000A5, 1, 32'h0000_F33F, 2, 1'b0);
      run_case(32'h0000_0300, 24'h0000A5, 1, 32'h0000_F337, 2, 1'b0);
      run_case(32'h0000_0508, 24'hA53C96, 3, 32'hD31F_9D3D, 4, 1'b0);
      run_case(32'h0000_0708, 24'h0000A5, 1, 32'h0000_00C5, 1, 1'b1);
      run_case(32'h0000_070A, 24'h0000A5, 1, 32'h0000_00C5, 1, 1'b1);
      rs_case();
      reset_case();
      print_verdict();
   end

   // Watchdog
   initial
   begin
      repeat (8000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule // fqm_top_tb
